// ===== rtl/ivpm_core.sv
// request mapping, level registers and priority resolution with vector output
//
// Behaviour
// R1: among equal-level pending requests the lowest request number wins.
// R2: every request number has its own two-bit level field.
// R3: external channel 4 raises request 0, vector bytes at fffa and fffb.
// R4: external channel 5 raises request 1, vector bytes at fff8 and fff9.
// R5: external channels 2 and 6 share request 2, vector at fff6 and fff7.
// R6: external channels 3 and 7 share request 3, vector at fff4 and fff5.
// R7: timer 0 lower half raises request 5, vector at fff0 and fff1.
// R8: timer 0 upper half raises request 6, vector at ffee and ffef.
// R9: timer 1 upper half raises request 14, vector at ffde and ffdf.
// R10: timer 1 lower half raises request 22, vector at ffce and ffcf.
// R11: six byte-wide level registers from index 79 hex, reset all ones.
// R12: request n vector upper byte at fffa minus 2n, lower byte next.
// R13: request numbers without a source never assert nor compete.
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module ivpm_core
    import ivpm_pkg::*;
#(
    parameter logic [23:0] PRESENT = IVPM_PRESENT_FULL
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire ivpm_sources_t src_in,
    input wire logic cpu_ack_in,
    input wire logic [9:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic irq_out,
    output logic grant_valid_out,
    output logic [4:0] grant_num_out,
    output logic [1:0] grant_level_out,
    output logic [15:0] vec_upper_addr_out,
    output logic [15:0] vec_lower_addr_out
);

    ////////////////////////////////////////////////////////////////////////
    // source to request mapping

    function automatic logic [23:0] map_sources(input ivpm_sources_t s);
        logic [23:0] r;
        r = 24'h000000;
        r[IVPM_REQ_EXT4] = s.ext[2]; // R3
        r[IVPM_REQ_EXT5] = s.ext[3]; // R4
        // shared lines: software polls the channel flags to tell them apart
        r[IVPM_REQ_EXT2_6] = s.ext[0] | s.ext[4]; // R5
        r[IVPM_REQ_EXT3_7] = s.ext[1] | s.ext[5]; // R6
        r[IVPM_REQ_T0_LO] = s.timer0_lo; // R7
        r[IVPM_REQ_T0_HI] = s.timer0_hi; // R8
        r[IVPM_REQ_SER_RX] = s.serial_rx;
        r[IVPM_REQ_SER_TX] = s.serial_tx;
        r[IVPM_REQ_T1_HI] = s.timer1_hi; // R9
        r[IVPM_REQ_ADC] = s.adc;
        r[IVPM_REQ_TBT] = s.timebase;
        r[IVPM_REQ_WATCH] = s.watch;
        r[IVPM_REQ_T1_LO] = s.timer1_lo; // R10
        r[IVPM_REQ_FLASH] = s.flash;
        return r & PRESENT; // R13
    endfunction

    function automatic logic [15:0] vector_of(input logic [4:0] n);
        return IVPM_VEC_TOP - {10'h000, n, 1'b0}; // R12
    endfunction

    function automatic logic [23:0] lane_mask(input logic [3:0] be);
        return {{8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    ivpm_state_t st;
    ivpm_state_t next_st;
    logic [23:0] raw;
    logic [23:0] cand;
    logic [7:0] idx;
    logic [7:0] lvl_sel;
    logic bus_req;
    logic acc_wr;
    logic lvl_hit;
    logic found;
    logic [4:0] best_num;
    logic [1:0] best_lvl;
    logic [23:0] clr;

    assign raw = map_sources(src_in);
    assign idx = avs_address_in[9:2];
    assign lvl_sel = idx - IVPM_LEVEL_BASE_IDX;
    assign lvl_hit = (idx >= IVPM_LEVEL_BASE_IDX) && (lvl_sel < IVPM_LEVEL_REG_COUNT);
    assign bus_req = avs_read_in | avs_write_in;
    // a write takes effect only in the cycle that waitrequest is low
    assign acc_wr = (st.bus == IVPM_BUS_RESP) && avs_write_in;
    assign cand = st.status & st.mask & PRESENT; // R13

    // lower level value is more urgent; strict compare keeps the lower number on ties
    always_comb begin
        found = 1'b0;
        best_num = 5'h00;
        best_lvl = 2'h3;
        for (int i = 0; i < IVPM_REQ_COUNT; i++) begin
            if (cand[i] && (!found || (st.levels[2*i +: 2] < best_lvl))) begin // R1 R2
                found = 1'b1;
                best_num = 5'(i);
                best_lvl = st.levels[2*i +: 2];
            end
        end
    end

    always_comb begin
        next_st = st;
        clr = 24'h000000;
        // bus: one wait cycle, then a single-cycle answer
        unique case (st.bus)
            IVPM_BUS_IDLE: begin
                next_st.rdata = 32'h00000000;
                if (bus_req) begin
                    next_st.bus = IVPM_BUS_RESP;
                    next_st.waitreq = 1'b0;
                    if (avs_read_in) begin
                        if (lvl_hit) begin
                            next_st.rdata = {24'h000000, st.levels[8*lvl_sel[2:0] +: 8]}; // R11
                        end else if (idx == IVPM_STATUS_IDX) begin
                            next_st.rdata = {8'h00, st.status};
                        end else if (idx == IVPM_MASK_IDX) begin
                            next_st.rdata = {8'h00, st.mask};
                        end
                    end
                end
            end
            IVPM_BUS_RESP: begin
                next_st.bus = IVPM_BUS_IDLE;
                next_st.waitreq = 1'b1;
                next_st.rdata = 32'h00000000;
            end
        endcase
        if (acc_wr) begin
            if (lvl_hit && avs_byteenable_in[0]) begin
                next_st.levels[8*lvl_sel[2:0] +: 8] = avs_writedata_in[7:0]; // R11 R2
            end
            if (idx == IVPM_STATUS_IDX) begin
                clr = avs_writedata_in[23:0] & lane_mask(avs_byteenable_in);
            end
            if (idx == IVPM_MASK_IDX) begin
                next_st.mask = (st.mask & ~lane_mask(avs_byteenable_in))
                    | (avs_writedata_in[23:0] & lane_mask(avs_byteenable_in) & PRESENT);
            end
        end
        // the cpu takes the granted request and retires its pending bit
        if (cpu_ack_in && st.grant_valid) begin
            clr[st.grant_num] = 1'b1;
        end
        // a new event in the clearing cycle survives
        next_st.status = ((st.status & ~clr) | raw) & PRESENT; // R13
        next_st.irq = |(next_st.status & next_st.mask);
        next_st.grant_valid = found;
        if (found) begin
            next_st.grant_num = best_num;
            next_st.grant_level = best_lvl;
            next_st.vec_upper = vector_of(best_num); // R12
            next_st.vec_lower = vector_of(best_num) + 16'h0001; // R12
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            st <= IVPM_STATE_RESET; // R11
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata_out = st.rdata;
    assign avs_waitrequest_out = st.waitreq;
    assign irq_out = st.irq;
    assign grant_valid_out = st.grant_valid;
    assign grant_num_out = st.grant_num;
    assign grant_level_out = st.grant_level;
    assign vec_upper_addr_out = st.vec_upper;
    assign vec_lower_addr_out = st.vec_lower;

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [23:0] prev_cand;
    logic [47:0] prev_levels;
    logic better_exists;

    always_ff @(posedge clock_in) begin
        prev_cand <= cand;
        prev_levels <= st.levels;
    end

    always_comb begin
        better_exists = 1'b0;
        for (int i = 0; i < IVPM_REQ_COUNT; i++) begin
            if ((5'(i) < st.grant_num) && prev_cand[i]
                && (prev_levels[2*i +: 2] <= st.grant_level)) begin
                better_exists = 1'b1;
            end
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    AST_TIE_LOWEST: assert property ($past(!rst_in) && st.grant_valid |-> !better_exists) // R1
        else $error("a lower numbered request of equal or better level was passed over");
    AST_LEVEL_WRITE: assert property (acc_wr && lvl_hit && avs_byteenable_in[0]
        |=> st.levels[8*$past(lvl_sel[2:0]) +: 8] == $past(avs_writedata_in[7:0])) // R2
        else $error("level register write did not land");
    AST_EXT4: assert property (src_in.ext[2] && PRESENT[0] |=> st.status[0]) // R3
        else $error("channel 4 did not raise request 0");
    AST_EXT5: assert property (src_in.ext[3] && PRESENT[1] |=> st.status[1]) // R4
        else $error("channel 5 did not raise request 1");
    AST_EXT26: assert property ((src_in.ext[0] || src_in.ext[4]) && PRESENT[2]
        |=> st.status[2]) // R5
        else $error("channel 2 or 6 did not raise request 2");
    AST_EXT37: assert property ((src_in.ext[1] || src_in.ext[5]) && PRESENT[3]
        |=> st.status[3]) // R6
        else $error("channel 3 or 7 did not raise request 3");
    AST_T0_LO: assert property (src_in.timer0_lo && PRESENT[5] |=> st.status[5]) // R7
        else $error("timer 0 lower did not raise request 5");
    AST_T0_HI: assert property (src_in.timer0_hi && PRESENT[6] |=> st.status[6]) // R8
        else $error("timer 0 upper did not raise request 6");
    AST_T1_HI: assert property (src_in.timer1_hi && PRESENT[14] |=> st.status[14]) // R9
        else $error("timer 1 upper did not raise request 14");
    AST_T1_LO: assert property (src_in.timer1_lo && PRESENT[22] |=> st.status[22]) // R10
        else $error("timer 1 lower did not raise request 22");
    AST_LEVEL_RESET: assert property ($past(rst_in) |-> st.levels == {6{IVPM_LEVEL_RESET}}) // R11
        else $error("level registers not all ones after reset");
    AST_VECTOR: assert property (st.grant_valid |-> (st.vec_upper
        == 16'hfffa - {10'h000, st.grant_num, 1'b0})
        && (st.vec_lower == st.vec_upper + 16'h0001)) // R12
        else $error("vector addresses do not match the granted request");
    AST_ABSENT: assert property ((st.status & ~PRESENT) == 24'h000000
        && !(st.grant_valid && !PRESENT[st.grant_num])) // R13
        else $error("request without a source is pending or granted");
    AST_IRQ_LEVEL: assert property (##1 irq_out == |(st.status & st.mask))
        else $error("interrupt output disagrees with unmasked status");
    AST_BUS_ANSWER: assert property (bus_req && st.bus == IVPM_BUS_IDLE
        |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("bus answer not a single cycle after one wait");

    ////////////////////////////////////////////////////////////////////////
    // register bus and reset checks

    AST_RESET_OUTPUTS: assert property ($past(rst_in) |-> avs_waitrequest_out
        && (avs_readdata_out == 32'h00000000) && !irq_out && !grant_valid_out
        && (st.status == IVPM_STATUS_RESET) && (st.mask == IVPM_MASK_RESET)) // R11
        else $error("outputs not at their reset values after reset");
    AST_RDATA_QUIET: assert property (avs_waitrequest_out |-> avs_readdata_out == 32'h00000000)
        else $error("read data showed outside the answer cycle");
    AST_WAIT_AFTER_ANSWER: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer stood for more than one cycle");
    // writes may only land in the answer cycle
    AST_NO_EARLY_WRITE: assert property (st.bus == IVPM_BUS_IDLE
        |=> (st.levels == $past(st.levels)) && (st.mask == $past(st.mask))) // R11
        else $error("a register changed before the answer cycle");
    AST_READ_NO_SIDE_EFFECT: assert property (st.bus == IVPM_BUS_RESP && !avs_write_in
        |=> (st.levels == $past(st.levels)) && (st.mask == $past(st.mask)))
        else $error("a read changed a register");
    AST_UNMAPPED_WRITE: assert property (acc_wr && !lvl_hit && (idx != IVPM_MASK_IDX)
        |=> (st.levels == $past(st.levels)) && (st.mask == $past(st.mask)))
        else $error("a write to another word changed a level or mask register");
    AST_MASK_WRITE: assert property (acc_wr && (idx == IVPM_MASK_IDX)
        && (avs_byteenable_in[2:0] == 3'h7)
        |=> st.mask == ($past(avs_writedata_in[23:0]) & PRESENT)) // R13
        else $error("mask write did not land or kept an absent bit");
    // a lane write of ones clears; an event in the same cycle wins
    AST_STATUS_W1C: assert property (acc_wr && (idx == IVPM_STATUS_IDX)
        && (avs_byteenable_in[2:0] == 3'h7)
        |=> (st.status & $past(avs_writedata_in[23:0]) & ~$past(raw)) == 24'h000000)
        else $error("status write of ones did not clear the pending bits");
    AST_LEVEL_READ: assert property (st.bus == IVPM_BUS_IDLE && avs_read_in && lvl_hit
        |=> avs_readdata_out == {24'h000000, $past(st.levels[8*lvl_sel[2:0] +: 8])}) // R11
        else $error("level register read returned the wrong byte");
    AST_STATUS_READ: assert property (st.bus == IVPM_BUS_IDLE && avs_read_in
        && (idx == IVPM_STATUS_IDX) |=> avs_readdata_out == {8'h00, $past(st.status)})
        else $error("status read returned the wrong value");
    // unmapped words still answer, with zero data
    AST_UNMAPPED_READ: assert property (st.bus == IVPM_BUS_IDLE && avs_read_in && !lvl_hit
        && (idx != IVPM_STATUS_IDX) && (idx != IVPM_MASK_IDX)
        |=> avs_readdata_out == 32'h00000000)
        else $error("unmapped read returned data");

    ////////////////////////////////////////////////////////////////////////
    // grant checks; grant outputs lag the candidates by one cycle

    // prev_cand and prev_levels are what the resolver saw for the current grant
    AST_GRANT_VALID: assert property ($past(!rst_in) |-> grant_valid_out == |prev_cand)
        else $error("grant valid disagrees with the candidates");
    AST_GRANT_PENDING: assert property (st.grant_valid |-> prev_cand[st.grant_num]) // R1
        else $error("granted request was not a candidate");
    AST_GRANT_LEVEL: assert property (st.grant_valid
        |-> st.grant_level == prev_levels[2*st.grant_num +: 2]) // R2
        else $error("grant level is not the level field of the granted request");
    AST_GRANT_STEADY: assert property ($past(!rst_in) && (prev_cand == $past(prev_cand))
        && (prev_levels == $past(prev_levels)) |-> $stable(grant_num_out)) // R1
        else $error("grant moved with no change in candidates or levels");
    AST_VEC_HOLD: assert property (!found
        |=> $stable(vec_upper_addr_out) && $stable(vec_lower_addr_out)) // R12
        else $error("vector outputs changed with no grant");
    AST_ACK_CLEAR: assert property (cpu_ack_in && st.grant_valid && !raw[st.grant_num]
        |=> !st.status[$past(st.grant_num)])
        else $error("cpu acknowledge did not retire the granted request");

    ////////////////////////////////////////////////////////////////////////
    // per-request pending bit and level field checks

    for (genvar g = 0; g < IVPM_REQ_COUNT; g++) begin : g_req_chk
        AST_PEND_SET: assert property (raw[g] |=> st.status[g]) // R13
            else $error("a mapped event did not set its pending bit");
        AST_PEND_CLEAR: assert property (clr[g] && !raw[g] |=> !st.status[g])
            else $error("a cleared pending bit stayed set");
        AST_PEND_HOLD: assert property (st.status[g] && !clr[g] |=> st.status[g])
            else $error("a pending bit dropped with no clear");
        AST_PEND_SPURIOUS: assert property (!st.status[g] && !raw[g] |=> !st.status[g])
            else $error("a pending bit rose with no event");
        AST_ABSENT_BIT: assert property (!PRESENT[g] |-> !st.status[g] && !st.mask[g]) // R13
            else $error("an absent request holds a pending or mask bit");
        AST_LEVEL_FIELD: assert property (acc_wr && lvl_hit && avs_byteenable_in[0]
            && (lvl_sel[2:0] == 3'(g / 4)) |=> st.levels[2*g +: 2]
            == $past(avs_writedata_in[2*(g%4) +: 2])) // R2
            else $error("a level field write missed its own request");
    end

    COV_TIE: cover property (st.grant_valid && $past(cand[0]) && $past(cand[1]));
    COV_ACK: cover property (cpu_ack_in && st.grant_valid ##1 st.grant_valid);
    COV_W1C: cover property (acc_wr && idx == IVPM_STATUS_IDX ##1 !irq_out);
    COV_SET_WINS: cover property (acc_wr && idx == IVPM_STATUS_IDX && |(raw & avs_writedata_in[23:0]));
    COV_LEVEL_WIN: cover property (st.grant_valid && st.grant_level == 2'h0 && st.grant_num != 5'h00);

endmodule

`default_nettype wire

// ===== inc/ivpm_pkg.sv
// constants, carrier structs and state type of the request map and priority block
package ivpm_pkg;

    localparam int IVPM_REQ_COUNT = 24;
    localparam logic [7:0] IVPM_LEVEL_BASE_IDX = 8'h79;
    localparam logic [7:0] IVPM_LEVEL_REG_COUNT = 8'h06;
    localparam logic [7:0] IVPM_STATUS_IDX = 8'h80;
    localparam logic [7:0] IVPM_MASK_IDX = 8'h81;
    localparam logic [7:0] IVPM_LEVEL_RESET = 8'hff;
    localparam logic [23:0] IVPM_STATUS_RESET = 24'h000000;
    localparam logic [23:0] IVPM_MASK_RESET = 24'h000000;
    localparam logic [15:0] IVPM_VEC_TOP = 16'hfffa;

    // request numbers of the mapped sources
    localparam int IVPM_REQ_EXT4 = 0;
    localparam int IVPM_REQ_EXT5 = 1;
    localparam int IVPM_REQ_EXT2_6 = 2;
    localparam int IVPM_REQ_EXT3_7 = 3;
    localparam int IVPM_REQ_T0_LO = 5;
    localparam int IVPM_REQ_T0_HI = 6;
    localparam int IVPM_REQ_SER_RX = 7;
    localparam int IVPM_REQ_SER_TX = 8;
    localparam int IVPM_REQ_T1_HI = 14;
    localparam int IVPM_REQ_ADC = 18;
    localparam int IVPM_REQ_TBT = 19;
    localparam int IVPM_REQ_WATCH = 20;
    localparam int IVPM_REQ_T1_LO = 22;
    localparam int IVPM_REQ_FLASH = 23;

    // request numbers that own a source, per product variant
    localparam logic [23:0] IVPM_PRESENT_FULL = 24'hdc41ef;
    localparam logic [23:0] IVPM_PRESENT_SMALL = 24'h9c0065;
    localparam logic [23:0] IVPM_PRESENT_MID = 24'h9c01ef;

    typedef struct packed {
        logic [5:0] ext;
        logic timer0_lo;
        logic timer0_hi;
        logic timer1_lo;
        logic timer1_hi;
        logic serial_rx;
        logic serial_tx;
        logic adc;
        logic timebase;
        logic watch;
        logic flash;
    } ivpm_sources_t;

    typedef enum logic [1:0] {
        IVPM_BUS_IDLE = 2'b01,
        IVPM_BUS_RESP = 2'b10
    } ivpm_bus_t;

    typedef struct packed {
        logic [47:0] levels;
        logic [23:0] status;
        logic [23:0] mask;
        ivpm_bus_t bus;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
        logic grant_valid;
        logic [4:0] grant_num;
        logic [1:0] grant_level;
        logic [15:0] vec_upper;
        logic [15:0] vec_lower;
    } ivpm_state_t;

    localparam ivpm_state_t IVPM_STATE_RESET = '{
        levels: {6{IVPM_LEVEL_RESET}},
        status: IVPM_STATUS_RESET,
        mask: IVPM_MASK_RESET,
        bus: IVPM_BUS_IDLE,
        waitreq: 1'b1,
        rdata: 32'h00000000,
        irq: 1'b0,
        grant_valid: 1'b0,
        grant_num: 5'h00,
        grant_level: 2'h3,
        vec_upper: IVPM_VEC_TOP,
        vec_lower: 16'hfffb
    };

endpackage

// ===== testbench/ivpm_cpu_model.sv
// cpu side model: takes the winning request after a set delay and acks it
`timescale 1ns/10ps
`default_nettype none
module ivpm_cpu_model (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic [3:0] delay_in,
    input wire logic grant_valid_in,
    input wire logic [4:0] grant_num_in,
    input wire logic [15:0] vec_upper_in,
    input wire logic [15:0] vec_lower_in,
    output logic ack_out,
    output logic [7:0] taken_out,
    output logic [4:0] num_out,
    output logic [31:0] vec_out
);
    logic [3:0] wait_cnt;
    logic [1:0] hold;
    always @(posedge clock_in) begin
        ack_out <= 1'b0;
        if (rst_in) begin
            wait_cnt <= 4'h0;
            hold <= 2'h0;
            taken_out <= 8'h00;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end else if (grant_valid_in && enable_in) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt >= delay_in) begin
                // grant outputs lag the ack by two edges, so stay off them
                ack_out <= 1'b1;
                hold <= 2'h3;
                wait_cnt <= 4'h0;
                taken_out <= taken_out + 8'h01;
                num_out <= grant_num_in;
                vec_out <= {vec_upper_in, vec_lower_in};
            end
        end else begin
            wait_cnt <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/tb_irq_vector_priority_map.sv
// self-checking bench of the request map and priority block
`timescale 1ns/10ps
`default_nettype none
module tb_irq_vector_priority_map;
    import ivpm_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    ivpm_sources_t src = '0;
    logic en = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [9:0] addr = 10'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, r, vec;
    logic ack, waitreq, irq, gvalid;
    logic [4:0] gnum, tnum;
    logic [1:0] glevel;
    logic [15:0] vup, vlo;
    logic [7:0] taken;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    int takes = 0;
    // indexed by source bit: flash, watch, timebase, adc, tx, rx, t1 hi/lo, t0 hi/lo, ext 2..7
    logic [4:0] exp_req [16] = '{23, 20, 19, 18, 8, 7, 14, 22, 6, 5, 2, 3, 0, 1, 2, 3};
    always #5 clock_in = ~clock_in;
    ivpm_core u_ivpm_core (.clock_in(clock_in), .rst_in(rst_in), .src_in(src),
        .cpu_ack_in(ack), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_byteenable_in(4'hf), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .irq_out(irq), .grant_valid_out(gvalid),
        .grant_num_out(gnum), .grant_level_out(glevel), .vec_upper_addr_out(vup),
        .vec_lower_addr_out(vlo));
    ivpm_cpu_model u_ivpm_cpu_model (.clock_in(clock_in), .rst_in(rst_in), .enable_in(en),
        .delay_in(dly), .grant_valid_in(gvalid), .grant_num_in(gnum), .vec_upper_in(vup),
        .vec_lower_in(vlo), .ack_out(ack), .taken_out(taken), .num_out(tnum), .vec_out(vec));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        do @(posedge clock_in); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic pulse(input ivpm_sources_t s);
        @(posedge clock_in);
        src <= s;
        @(posedge clock_in);
        src <= '0;
    endtask
    task automatic take(input logic [4:0] n);
        takes++;
        while (taken !== 8'(takes)) @(posedge clock_in);
        check("taken request", 32'(n), 32'(tnum));
        check("vector", {16'hfffa - {10'h0, n, 1'b0}, 16'hfffb - {10'h0, n, 1'b0}}, vec);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("irq", 32'h0, 32'(irq));
        check("grant level", 32'h3, 32'(glevel));
        check("grant valid", 32'h0, 32'(gvalid));
        check("waitrequest", 32'h1, 32'(waitreq));
        check("vector", 32'hfffafffb, {vup, vlo});
        for (int k = 0; k < 6; k++) begin
            bus(1'b0, 10'h1e4 + 10'(4 * k), 32'h0, r);
            check("level reg", 32'hff, r);
        end
        bus(1'b0, 10'h3fc, 32'h0, r);
        check("unmapped", 32'h0, r);
        $display("test reset done");
    endtask
    task automatic t_map();
        bus(1'b1, 10'h204, 32'hffffffff, r);
        bus(1'b0, 10'h204, 32'h0, r);
        check("mask", 32'(IVPM_PRESENT_FULL), r);
        en <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            dly <= 4'(i % 4);
            pulse(ivpm_sources_t'(16'h1 << i));
            take(exp_req[i]);
        end
        $display("test map done");
    endtask
    task automatic t_prio();
        en <= 1'b0;
        // channel 4, converter and flash in the same cycle
        pulse(ivpm_sources_t'(16'h1009));
        repeat (4) @(posedge clock_in);
        check("grant valid", 32'h1, 32'(gvalid));
        check("grant", 32'h0, 32'(gnum));
        en <= 1'b1;
        take(5'd0);
        take(5'd18);
        take(5'd23);
        en <= 1'b0;
        bus(1'b1, 10'h1f4, 32'hffffffcf, r);
        bus(1'b0, 10'h1f4, 32'h0, r);
        check("level reg", 32'hcf, r);
        pulse(ivpm_sources_t'(16'h1008));
        repeat (4) @(posedge clock_in);
        check("grant", 32'd18, 32'(gnum));
        check("grant level", 32'h0, 32'(glevel));
        en <= 1'b1;
        take(5'd18);
        take(5'd0);
        bus(1'b1, 10'h1f4, 32'hff, r);
        $display("test priority done");
    endtask
    task automatic t_irq();
        en <= 1'b0;
        bus(1'b1, 10'h204, 32'h00cc41ef, r);
        pulse(ivpm_sources_t'(16'h0002));
        repeat (3) @(posedge clock_in);
        check("irq masked", 32'h0, 32'(irq));
        bus(1'b0, 10'h200, 32'h0, r);
        check("status", 32'h100000, r);
        bus(1'b1, 10'h204, 32'h00dc41ef, r);
        repeat (2) @(posedge clock_in);
        check("irq", 32'h1, 32'(irq));
        check("grant", 32'd20, 32'(gnum));
        bus(1'b1, 10'h200, 32'h100000, r);
        repeat (2) @(posedge clock_in);
        check("irq cleared", 32'h0, 32'(irq));
        check("grant valid", 32'h0, 32'(gvalid));
        $display("test interrupt done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("counts: checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("mismatch run length expected finish seen hang");
            finish_test();
        end
    end
    initial begin
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        t_reset();
        t_map();
        t_prio();
        t_irq();
        finish_test();
    end
endmodule
`default_nettype wire
